/* File: vowc_top.v */
// first video window and icon overlay control register bank with apb slave
`timescale 1ns/10ps
`include "vowc_map.vh"
module vowc_top (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // display timing from the compositor
   input  wire        video_active,
   input  wire        frame_start,
   input  wire        odd_field,
   input  wire        flip_req_sw,
   input  wire        flip_req_qve,
   input  wire        flip_req_cap0,
   input  wire        flip_req_cap1,
   input  wire        line_flip_req,
   input  wire [7:0]  fifo_level,
   // window controls to compose and fetch
   output reg         win_visible,
   output reg         win_to_second,
   output reg         flip_take,
   output reg         line_flip_take,
   output reg  [10:0] eff_stride,
   output reg         extra_top_line,
   output reg  [4:0]  expire_count,
   output reg  [6:0]  expire_requests,
   output reg         csc_active,
   output reg  [5:0]  format_onehot,
   output reg         format_reserved,
   output reg  [10:0] win_x_start,
   output reg  [10:0] win_y_start,
   output reg  [10:0] win_x_end,
   output reg  [10:0] win_y_end,
   output reg  [4:0]  h_minify_factor,
   output reg  [4:0]  v_minify_factor,
   output reg         minify_reserved,
   output reg         h_interp,
   output reg         v_interp,
   output reg         v_interp_chroma,
   output reg  [28:0] fetch_byte_addr,
   output reg         fetch_system_mem,
   output reg  [8:0]  fifo_depth,
   output reg         req_high_prio,
   output reg         req_early,
   // icon overlay controls
   output reg  [7:0]  icon_size,
   output reg  [3:0]  icon_format_onehot,
   output reg         icon_alpha_high_byte,
   output reg         icon_enable,
   output reg  [3:0]  icon_alpha
);
   // register storage
   reg  [31:0] stream_ctrl_r;  // window stream control
   reg  [31:0] fetch_cnt_r;    // line fetch count
   reg  [31:0] addr_second_r;  // second buffer address
   reg  [31:0] stride_r;       // packed stride
   reg  [31:0] start_pos_r;    // start location minus one
   reg  [31:0] end_pos_r;      // end location minus one
   reg  [31:0] addr_third_r;   // third buffer address
   reg  [31:0] zoom_r;         // zoom control
   reg  [31:0] minify_r;       // minify and interpolation
   reg  [31:0] addr_first_r;   // first buffer address, read-only view
   reg  [31:0] fifo_ctrl_r;    // fifo depth and thresholds
   reg  [31:0] start_ofs_r;    // start location offset
   reg  [31:0] icon_ctrl_r;    // icon control
   reg  [31:0] rdata_nxt;      // read mux
   reg         hit_nxt;        // address decodes
   wire        wr_en;          // apb write strobe in access phase
   wire        rd_en;          // apb read in access phase
   wire [3:0]  fade_alpha;     // fader result
   reg  [2:0]  h_min;          // horizontal minify code
   reg  [2:0]  v_min;          // vertical minify code
   reg  [1:0]  addr_keep;      // honoured low address bits
   assign wr_en = psel & penable & pwrite & ~pready;
   assign rd_en = psel & penable & ~pwrite & ~pready;
   // read mux and address decode
   always @* begin
      hit_nxt   = 1'b1;
      rdata_nxt = 32'h00000000;
      case (paddr)
         `VOWC_OFF_STREAM_CTRL:  rdata_nxt = stream_ctrl_r;
         `VOWC_OFF_FETCH_CNT:    rdata_nxt = fetch_cnt_r;
         `VOWC_OFF_ADDR_SECOND:  rdata_nxt = addr_second_r;
         `VOWC_OFF_STRIDE:       rdata_nxt = stride_r;
         `VOWC_OFF_START_POS:    rdata_nxt = start_pos_r;
         `VOWC_OFF_END_POS:      rdata_nxt = end_pos_r;
         `VOWC_OFF_ADDR_THIRD:   rdata_nxt = addr_third_r;
         `VOWC_OFF_ZOOM:         rdata_nxt = zoom_r;
         `VOWC_OFF_MINIFY:       rdata_nxt = minify_r;
         `VOWC_OFF_ADDR_FIRST:   rdata_nxt = addr_first_r;
         `VOWC_OFF_ADDR_FIRST_W: rdata_nxt = addr_first_r;
         `VOWC_OFF_FIFO_CTRL:    rdata_nxt = fifo_ctrl_r;
         `VOWC_OFF_START_OFS:    rdata_nxt = start_ofs_r;
         `VOWC_OFF_ICON_CTRL:    rdata_nxt = icon_ctrl_r;
         default:                hit_nxt = 1'b0;
      endcase
   end
   // apb answer: one wait state, error on unmapped address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit_nxt;
         prdata  <= rd_en ? rdata_nxt : 32'h00000000;
      end
   end
   // register writes with reserved bits masked
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stream_ctrl_r <= `VOWC_RST_ZERO;
         fetch_cnt_r   <= `VOWC_RST_ZERO;
         addr_second_r <= `VOWC_RST_ZERO;
         stride_r      <= `VOWC_RST_ZERO;
         start_pos_r   <= `VOWC_RST_ZERO;
         end_pos_r     <= `VOWC_RST_ZERO;
         addr_third_r  <= `VOWC_RST_ZERO;
         zoom_r        <= `VOWC_RST_ZERO;
         minify_r      <= `VOWC_RST_ZERO;
         addr_first_r  <= `VOWC_RST_ZERO;
         fifo_ctrl_r   <= `VOWC_RST_ZERO;
         start_ofs_r   <= `VOWC_RST_ZERO;
         icon_ctrl_r   <= `VOWC_RST_ICON_CTRL;
      end else if (wr_en) begin
         case (paddr)
            `VOWC_OFF_STREAM_CTRL:  stream_ctrl_r <= pwdata & `VOWC_MASK_STREAM_CTRL;
            `VOWC_OFF_FETCH_CNT:    fetch_cnt_r   <= pwdata & `VOWC_MASK_FETCH_CNT;
            `VOWC_OFF_ADDR_SECOND:  addr_second_r <= pwdata & `VOWC_MASK_ADDR;
            `VOWC_OFF_STRIDE:       stride_r      <= pwdata & `VOWC_MASK_STRIDE;
            `VOWC_OFF_START_POS:    start_pos_r   <= pwdata & `VOWC_MASK_POS;
            `VOWC_OFF_END_POS:      end_pos_r     <= pwdata & `VOWC_MASK_POS;
            `VOWC_OFF_ADDR_THIRD:   addr_third_r  <= pwdata & `VOWC_MASK_ADDR;
            `VOWC_OFF_ZOOM:         zoom_r        <= pwdata & `VOWC_MASK_ZOOM;
            `VOWC_OFF_MINIFY:       minify_r      <= pwdata & `VOWC_MASK_MINIFY;
            `VOWC_OFF_ADDR_FIRST_W: addr_first_r  <= pwdata & `VOWC_MASK_ADDR_FIRST;
            `VOWC_OFF_FIFO_CTRL:    fifo_ctrl_r   <= pwdata & `VOWC_MASK_FIFO_CTRL;
            `VOWC_OFF_START_OFS:    start_ofs_r   <= pwdata & `VOWC_MASK_POS;
            `VOWC_OFF_ICON_CTRL:    icon_ctrl_r   <= pwdata & `VOWC_MASK_ICON_CTRL;
            default:                icon_ctrl_r   <= icon_ctrl_r;
         endcase
      end
   end
   // icon fade stepper
   vowc_fade i_vowc_fade (
      .pclk        (pclk),
      .presetn     (presetn),
      .fade_en     (icon_ctrl_r[8]),
      .fade_up     (icon_ctrl_r[9]),
      .step        (icon_ctrl_r[15:12]),
      .const_alpha ({icon_ctrl_r[7:4], icon_ctrl_r[19:16]}),
      .frame_start (frame_start),
      .alpha_out   (fade_alpha)
   );
   // minify and packed address alignment decode
   always @* begin
      h_min = minify_r[26:24];
      v_min = minify_r[18:16];
      if (h_min == `VOWC_MIN_NONE) begin
         addr_keep = 2'b11;
      end else if (h_min == `VOWC_MIN_2) begin
         addr_keep = 2'b10;
      end else begin
         addr_keep = 2'b00;
      end
   end
   // window control outputs, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_visible     <= 1'b0;
         win_to_second   <= 1'b0;
         flip_take       <= 1'b0;
         line_flip_take  <= 1'b0;
         eff_stride      <= 11'h000;
         extra_top_line  <= 1'b0;
         expire_count    <= 5'h00;
         expire_requests <= 7'h00;
         csc_active      <= 1'b0;
         format_onehot   <= 6'h00;
         format_reserved <= 1'b0;
         win_x_start     <= 11'h000;
         win_y_start     <= 11'h000;
         win_x_end       <= 11'h000;
         win_y_end       <= 11'h000;
         h_minify_factor <= 5'h01;
         v_minify_factor <= 5'h01;
         minify_reserved <= 1'b0;
         h_interp        <= 1'b0;
         v_interp        <= 1'b0;
         v_interp_chroma <= 1'b0;
         fetch_byte_addr <= 29'h00000000;
         fetch_system_mem <= 1'b0;
         fifo_depth      <= 9'h000;
         req_high_prio   <= 1'b0;
         req_early       <= 1'b0;
         icon_size       <= 8'h00;
         icon_format_onehot <= 4'h0;
         icon_alpha_high_byte <= 1'b0;
         icon_enable     <= 1'b0;
         icon_alpha      <= 4'hf;
      end else begin
         win_visible   <= stream_ctrl_r[0];
         win_to_second <= stream_ctrl_r[31];
         // flip source selection
         case (stream_ctrl_r[26:25])
            2'b00:   flip_take <= flip_req_sw;
            2'b01:   flip_take <= flip_req_qve;
            2'b10:   flip_take <= flip_req_cap0;
            default: flip_take <= flip_req_cap1;
         endcase
         line_flip_take <= line_flip_req & ~(stream_ctrl_r[21] & video_active);
         eff_stride <= stream_ctrl_r[24] ? {stride_r[13:4], 1'b0}
                                         : {1'b0, stride_r[13:4]};
         extra_top_line  <= stream_ctrl_r[22] & odd_field;
         expire_count    <= stream_ctrl_r[20:16];
         expire_requests <= {stream_ctrl_r[20:16], 2'b00};
         csc_active      <= ~stream_ctrl_r[8];
         // stream format decode
         format_reserved <= (stream_ctrl_r[4:2] > 3'h5);
         case (stream_ctrl_r[4:2])
            3'h0:    format_onehot <= 6'h01;
            3'h1:    format_onehot <= 6'h02;
            3'h2:    format_onehot <= 6'h04;
            3'h3:    format_onehot <= 6'h08;
            3'h4:    format_onehot <= 6'h10;
            3'h5:    format_onehot <= 6'h20;
            default: format_onehot <= 6'h00;
         endcase
         win_x_start <= start_pos_r[26:16] + 11'h001;
         win_y_start <= start_pos_r[10:0] + 11'h001;
         win_x_end   <= end_pos_r[26:16] + 11'h001;
         win_y_end   <= end_pos_r[10:0] + 11'h001;
         // minify factors, zero on reserved codes
         case (h_min)
            `VOWC_MIN_NONE: h_minify_factor <= 5'h01;
            `VOWC_MIN_2:    h_minify_factor <= 5'h02;
            `VOWC_MIN_4:    h_minify_factor <= 5'h04;
            `VOWC_MIN_8:    h_minify_factor <= 5'h08;
            `VOWC_MIN_16:   h_minify_factor <= 5'h10;
            default:        h_minify_factor <= 5'h00;
         endcase
         case (v_min)
            `VOWC_MIN_NONE: v_minify_factor <= 5'h01;
            `VOWC_MIN_2:    v_minify_factor <= 5'h02;
            `VOWC_MIN_4:    v_minify_factor <= 5'h04;
            `VOWC_MIN_8:    v_minify_factor <= 5'h08;
            `VOWC_MIN_16:   v_minify_factor <= 5'h10;
            default:        v_minify_factor <= 5'h00;
         endcase
         minify_reserved <= (h_min == 3'h2) | (h_min == 3'h4) | (h_min == 3'h6) |
                            (v_min == 3'h2) | (v_min == 3'h4) | (v_min == 3'h6);
         h_interp        <= minify_r[1];
         v_interp        <= minify_r[0];
         v_interp_chroma <= minify_r[0] & minify_r[2];
         fetch_byte_addr <= {addr_first_r[28:4], addr_first_r[3:2] & addr_keep, 2'b00};
         fetch_system_mem <= (addr_first_r[30:29] == 2'b01);
         fifo_depth    <= {1'b0, fifo_ctrl_r[7:0]} + 9'h001;
         req_high_prio <= (fifo_level < fifo_ctrl_r[15:8]);
         req_early     <= (fifo_level <= fifo_ctrl_r[31:24]);
         // icon decode
         case (icon_ctrl_r[27:26])
            2'b00:   icon_size <= 8'd32;
            2'b01:   icon_size <= 8'd64;
            default: icon_size <= 8'd128;
         endcase
         case (icon_ctrl_r[25:24])
            2'b00:   icon_format_onehot <= 4'h1;
            2'b01:   icon_format_onehot <= 4'h2;
            2'b10:   icon_format_onehot <= 4'h4;
            default: icon_format_onehot <= 4'h8;
         endcase
         icon_alpha_high_byte <= icon_ctrl_r[28];
         icon_enable <= icon_ctrl_r[0];
         icon_alpha  <= fade_alpha;
      end
   end
endmodule // vowc_top

/* File: vowc_map.vh */
// register offsets, field positions and reset values of the window control block
`ifndef VOWC_MAP_VH
`define VOWC_MAP_VH
`define VOWC_OFF_STREAM_CTRL  12'h230
`define VOWC_OFF_FETCH_CNT    12'h234
`define VOWC_OFF_ADDR_SECOND  12'h238
`define VOWC_OFF_STRIDE       12'h23c
`define VOWC_OFF_START_POS    12'h240
`define VOWC_OFF_END_POS      12'h244
`define VOWC_OFF_ADDR_THIRD   12'h248
`define VOWC_OFF_ZOOM         12'h24c
`define VOWC_OFF_MINIFY       12'h250
`define VOWC_OFF_ADDR_FIRST   12'h254
`define VOWC_OFF_FIFO_CTRL    12'h258
`define VOWC_OFF_START_OFS    12'h25c
`define VOWC_OFF_ICON_CTRL    12'h260
`define VOWC_OFF_ADDR_FIRST_W 12'h2c0
`define VOWC_MASK_STREAM_CTRL 32'hff7f039d
`define VOWC_MASK_FETCH_CNT   32'h3ff00000
`define VOWC_MASK_ADDR        32'h7ffffff8
`define VOWC_MASK_ADDR_FIRST  32'h7ffffffc
`define VOWC_MASK_STRIDE      32'h00003ff0
`define VOWC_MASK_POS         32'h07ff07ff
`define VOWC_MASK_ZOOM        32'h87ff83ff
`define VOWC_MASK_MINIFY      32'h07070007
`define VOWC_MASK_FIFO_CTRL   32'hff00ffff
`define VOWC_MASK_ICON_CTRL   32'hff0ffff5
`define VOWC_RST_ICON_CTRL    32'h000f00f0
`define VOWC_RST_ZERO         32'h00000000
`define VOWC_MIN_NONE         3'h0
`define VOWC_MIN_2            3'h1
`define VOWC_MIN_4            3'h3
`define VOWC_MIN_8            3'h5
`define VOWC_MIN_16           3'h7
`endif

/* File: vowc_fade.v */
// per-frame icon alpha fade stepper
`timescale 1ns/10ps
module vowc_fade (
   // clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // control
   input  wire       fade_en,
   input  wire       fade_up,
   input  wire [3:0] step,
   input  wire [7:0] const_alpha,
   input  wire       frame_start,
   // result
   output reg  [3:0] alpha_out
);
   reg [7:0] alpha_r;   // running eight-bit alpha
   reg [7:0] alpha_nxt; // next alpha
   // step value, saturated at the range ends
   always @* begin
      alpha_nxt = alpha_r;
      if (!fade_en) begin
         alpha_nxt = const_alpha;
      end else if (frame_start) begin
         if (fade_up) begin
            alpha_nxt = (alpha_r > (8'hff - {4'h0, step})) ? 8'hff
                        : alpha_r + {4'h0, step};
         end else begin
            alpha_nxt = (alpha_r < {4'h0, step}) ? 8'h00
                        : alpha_r - {4'h0, step};
         end
      end
   end
   // register alpha; only the upper nibble is visible
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alpha_r   <= 8'hff;
         alpha_out <= 4'hf;
      end else begin
         alpha_r   <= alpha_nxt;
         alpha_out <= alpha_nxt[7:4];
      end
   end
endmodule // vowc_fade

/* File: vowc_chk.sv */
// port checker for the window control register bank
`timescale 1ns/10ps
module vowc_chk (
   // clock, reset and apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire [31:0] prdata,
   // window controls
   input wire        line_flip_req,
   input wire        line_flip_take,
   input wire [4:0]  expire_count,
   input wire [6:0]  expire_requests,
   input wire        v_interp,
   input wire        v_interp_chroma,
   input wire [5:0]  format_onehot,
   input wire        format_reserved,
   input wire [28:0] fetch_byte_addr,
   input wire [4:0]  h_minify_factor,
   input wire        minify_reserved
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into the access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without an access phase");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside the answer cycle");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
      else $error("prdata not zero outside the answer cycle");
   a_expire_scale: assert property (expire_requests == {expire_count, 2'b00})
      else $error("expire requests not four times the count");
   a_chroma_vert: assert property (v_interp_chroma |-> v_interp)
      else $error("chroma interpolation without vertical interpolation");
   a_format_code: assert property ($onehot0(format_onehot) &&
      !(format_reserved && format_onehot != 6'h00))
      else $error("format decode not one-hot or reserved clash");
   a_flip_cause: assert property (line_flip_take |-> $past(line_flip_req))
      else $error("line flip taken without a request");
   a_addr_align: assert property (fetch_byte_addr[1:0] == 2'b00 &&
      (h_minify_factor == 5'h01 || !fetch_byte_addr[2]) &&
      (h_minify_factor <= 5'h02 || fetch_byte_addr[3:2] == 2'b00))
      else $error("fetch address keeps low bits beyond minify alignment");
   a_minify_pow: assert property ($onehot0(h_minify_factor) &&
      (h_minify_factor != 5'h00 || minify_reserved))
      else $error("minify factor not a power of two");
   c_slverr: cover property (pready && pslverr);
   c_line_flip: cover property (line_flip_take);
   c_chroma: cover property (v_interp_chroma);
endmodule // vowc_chk
bind vowc_top vowc_chk i_vowc_chk (.*);

/* File: vowc_far.sv */
// far-side model: display timing and fetch fifo fill toward the window control
`timescale 1ns/10ps
module vowc_far (
   // clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // bench controls: active, odd, four flips, line flip, frame request
   input  wire [7:0] knob,
   input  wire [7:0] lvl_k,
   // timing and fifo state
   output reg        video_active,
   output reg        odd_field,
   output reg  [3:0] flip_req,
   output reg        line_flip_req,
   output reg        frame_start,
   output reg  [7:0] fifo_level
);
   reg frame_go_r;  // last frame request, so each request gives one pulse
   // timing follows the controls one edge later, like a real compositor
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {video_active, odd_field, flip_req, line_flip_req, frame_start} <= 8'h00;
         frame_go_r <= 1'b0;
         fifo_level <= 8'h00;
      end else begin
         {line_flip_req, flip_req, odd_field, video_active} <= knob[6:0];
         frame_start <= knob[7] & ~frame_go_r;
         frame_go_r  <= knob[7];
         fifo_level  <= lvl_k;
      end
   end
endmodule // vowc_far

/* File: video_overlay_window_control_bench.sv */
// testbench for the window control register bank
`timescale 1ns/10ps
`include "vowc_map.vh"
module video_overlay_window_control_bench;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000;
   reg [7:0]  knob = 8'h00, lvl_k = 8'h00;  // far-side controls
   wire [31:0] prdata;
   wire [28:0] fetch_byte_addr;
   wire [10:0] eff_stride, win_x_start, win_y_start, win_x_end, win_y_end;
   wire [8:0]  fifo_depth;
   wire [7:0]  fifo_level, icon_size;
   wire [6:0]  expire_requests;
   wire [5:0]  format_onehot;
   wire [4:0]  expire_count, h_minify_factor, v_minify_factor;
   wire [3:0]  flip_req, icon_format_onehot, icon_alpha;
   wire pready, pslverr, video_active, frame_start, odd_field, line_flip_req, win_visible;
   wire win_to_second, flip_take, line_flip_take, extra_top_line, csc_active, format_reserved;
   wire minify_reserved, h_interp, v_interp, v_interp_chroma, fetch_system_mem, req_high_prio;
   wire req_early, icon_alpha_high_byte, icon_enable;
   integer errors = 0, total_checks = 0, i, j;
   reg [11:0] a;
   reg [7:0]  lvls [0:4] = '{8'h08, 8'h0f, 8'h10, 8'h20, 8'h21};
   vowc_far i_vowc_far (.*);
   vowc_top i_vowc_top (.*, .flip_req_sw(flip_req[0]), .flip_req_qve(flip_req[1]),
      .flip_req_cap0(flip_req[2]), .flip_req_cap1(flip_req[3]));
   // 50 MHz clock
   always #10 pclk = ~pclk;
   // compare and count
   task see(input string n, input logic [31:0] exp, input logic [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", n, exp, got);
         end
      end
   endtask
   // one apb transfer: setup, access held until pready is seen high
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
            output logic [31:0] q, output logic e);
      begin
         @(posedge pclk);
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= ad;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         q = prdata;
         e = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // write, then let derived outputs settle
   task wr(input logic [11:0] ad, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      begin
         apb(1'b1, ad, d, q, e);
         repeat (2) @(negedge pclk);
      end
   endtask
   // read and compare data and error response
   task rdc(input logic [11:0] ad, input logic [31:0] exp, input logic experr);
      logic [31:0] q;
      logic e;
      begin
         apb(1'b0, ad, 32'h00000000, q, e);
         see("prdata", exp, q);
         see("pslverr", experr, e);
      end
   endtask
   // wait for far-side changes to pass through
   task settle;
      begin
         repeat (3) @(posedge pclk);
         @(negedge pclk);
      end
   endtask
   // n frame starts
   task frames(input integer n);
      begin
         repeat (n) begin
            @(posedge pclk);
            knob[7] <= 1'b1;
            @(posedge pclk);
            knob[7] <= 1'b0;
         end
         settle;
      end
   endtask
   // writable bits of each register
   function logic [31:0] mask(input logic [11:0] ad);
      case (ad)
         `VOWC_OFF_STREAM_CTRL: mask = `VOWC_MASK_STREAM_CTRL;
         `VOWC_OFF_FETCH_CNT: mask = `VOWC_MASK_FETCH_CNT;
         `VOWC_OFF_ADDR_SECOND, `VOWC_OFF_ADDR_THIRD: mask = `VOWC_MASK_ADDR;
         `VOWC_OFF_STRIDE: mask = `VOWC_MASK_STRIDE;
         `VOWC_OFF_ZOOM: mask = `VOWC_MASK_ZOOM;
         `VOWC_OFF_MINIFY: mask = `VOWC_MASK_MINIFY;
         `VOWC_OFF_FIFO_CTRL: mask = `VOWC_MASK_FIFO_CTRL;
         `VOWC_OFF_ICON_CTRL: mask = `VOWC_MASK_ICON_CTRL;
         `VOWC_OFF_ADDR_FIRST: mask = 32'h00000000;
         default: mask = `VOWC_MASK_POS;
      endcase
   endfunction
   // minify code to factor, zero for reserved codes
   function logic [4:0] fac(input integer c);
      case (c)
         0: fac = 5'h01;
         1: fac = 5'h02;
         3: fac = 5'h04;
         5: fac = 5'h08;
         7: fac = 5'h10;
         default: fac = 5'h00;
      endcase
   endfunction
   // verdict and end of run
   task summarize;
      begin
         $display("checks %0d mismatches %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      errors = errors + 1;
      summarize;
   end
   // main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      see("icon_alpha", 4'hf, icon_alpha);
      see("h_minify_factor", 5'h01, h_minify_factor);
      a = `VOWC_OFF_STREAM_CTRL;
      for (i = 0; i < 13; i = i + 1) begin
         rdc(a, (a == `VOWC_OFF_ICON_CTRL) ? `VOWC_RST_ICON_CTRL : `VOWC_RST_ZERO, 1'b0);
         wr(a, 32'hffffffff);
         rdc(a, mask(a), 1'b0);
         wr(a, (a == `VOWC_OFF_ICON_CTRL) ? `VOWC_RST_ICON_CTRL : `VOWC_RST_ZERO);
         a = a + 12'h004;
      end
      rdc(12'h300, 32'h00000000, 1'b1);
      $display("register map done");
      wr(`VOWC_OFF_STREAM_CTRL, 32'h80000001);
      see("win_visible", 1'b1, win_visible);
      see("win_to_second", 1'b1, win_to_second);
      see("csc_active", 1'b1, csc_active);
      wr(`VOWC_OFF_STREAM_CTRL, 32'h00000100);
      see("win_visible", 1'b0, win_visible);
      see("win_to_second", 1'b0, win_to_second);
      see("csc_active", 1'b0, csc_active);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`VOWC_OFF_STREAM_CTRL, {5'h00, i[1:0], 25'h0000001});
         for (j = 0; j < 4; j = j + 1) begin
            @(posedge pclk);
            knob[5:2] <= 4'h1 << j;
            settle;
            see("flip_take", i == j, flip_take);
         end
      end
      knob <= 8'h00;
      wr(`VOWC_OFF_STRIDE, 32'h00003ff0);
      wr(`VOWC_OFF_STREAM_CTRL, 32'h00000000);
      see("eff_stride", 11'h3ff, eff_stride);
      wr(`VOWC_OFF_STREAM_CTRL, 32'h01000000);
      see("eff_stride", 11'h7fe, eff_stride);
      $display("stream control done");
      wr(`VOWC_OFF_STREAM_CTRL, 32'h007f0000);
      see("expire_count", 5'h1f, expire_count);
      see("expire_requests", 7'h7c, expire_requests);
      knob <= 8'h43;
      settle;
      see("extra_top_line", 1'b1, extra_top_line);
      see("line_flip_take", 1'b0, line_flip_take);
      knob <= 8'h40;
      settle;
      see("line_flip_take", 1'b1, line_flip_take);
      wr(`VOWC_OFF_STREAM_CTRL, 32'h00000000);
      knob <= 8'h43;
      settle;
      see("extra_top_line", 1'b0, extra_top_line);
      see("line_flip_take", 1'b1, line_flip_take);
      knob <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
         wr(`VOWC_OFF_STREAM_CTRL, {27'h0000000, i[2:0], 2'b00});
         see("format_onehot", (i < 6) ? (32'h1 << i) : 32'h0, format_onehot);
         see("format_reserved", i > 5, format_reserved);
      end
      wr(`VOWC_OFF_START_POS, 32'h07ff0005);
      see("win_x_start", 11'h000, win_x_start);
      see("win_y_start", 11'h006, win_y_start);
      wr(`VOWC_OFF_END_POS, 32'h031f0257);
      see("win_x_end", 11'h320, win_x_end);
      see("win_y_end", 11'h258, win_y_end);
      for (i = 0; i < 8; i = i + 1) begin
         wr(`VOWC_OFF_MINIFY, {5'h00, i[2:0], 5'h00, ~i[2:0], 13'h0000, i[2:0]});
         see("h_minify_factor", fac(i), h_minify_factor);
         see("v_minify_factor", fac(7 - i), v_minify_factor);
         see("minify_reserved", fac(i) == 0 || fac(7 - i) == 0, minify_reserved);
         see("h_interp", i[1], h_interp);
         see("v_interp", i[0], v_interp);
         see("v_interp_chroma", i[0] & i[2], v_interp_chroma);
      end
      $display("window geometry done");
      wr(`VOWC_OFF_MINIFY, 32'h00000000);
      wr(`VOWC_OFF_ADDR_FIRST_W, 32'h3000000c);
      wr(`VOWC_OFF_ADDR_FIRST, 32'h00000000);
      rdc(`VOWC_OFF_ADDR_FIRST, 32'h3000000c, 1'b0);
      see("fetch_system_mem", 1'b1, fetch_system_mem);
      see("fetch_byte_addr", 29'h1000000c, fetch_byte_addr);
      wr(`VOWC_OFF_MINIFY, 32'h01000000);
      see("fetch_byte_addr", 29'h10000008, fetch_byte_addr);
      wr(`VOWC_OFF_MINIFY, 32'h03000000);
      see("fetch_byte_addr", 29'h10000000, fetch_byte_addr);
      wr(`VOWC_OFF_FIFO_CTRL, 32'h2000103f);
      see("fifo_depth", 9'h040, fifo_depth);
      for (i = 0; i < 5; i = i + 1) begin
         lvl_k <= lvls[i];
         settle;
         see("req_high_prio", lvls[i] < 8'h10, req_high_prio);
         see("req_early", lvls[i] <= 8'h20, req_early);
      end
      $display("fetch control done");
      for (i = 0; i < 4; i = i + 1) begin
         wr(`VOWC_OFF_ICON_CTRL, {3'b000, i[0], i[1:0], i[1:0], 24'h0f00f1});
         see("icon_size", (i == 0) ? 32 : (i == 1) ? 64 : 128, icon_size);
         see("icon_format_onehot", 32'h1 << i, icon_format_onehot);
         see("icon_alpha_high_byte", i[0], icon_alpha_high_byte);
         see("icon_enable", 1'b1, icon_enable);
      end
      wr(`VOWC_OFF_ICON_CTRL, 32'h00000080);
      see("icon_alpha", 4'h8, icon_alpha);
      see("icon_enable", 1'b0, icon_enable);
      wr(`VOWC_OFF_ICON_CTRL, 32'h00008380);
      frames(2);
      see("icon_alpha", 4'h9, icon_alpha);
      frames(16);
      see("icon_alpha", 4'hf, icon_alpha);
      wr(`VOWC_OFF_ICON_CTRL, 32'h00000080);
      wr(`VOWC_OFF_ICON_CTRL, 32'h00008180);
      frames(3);
      see("icon_alpha", 4'h6, icon_alpha);
      frames(16);
      see("icon_alpha", 4'h0, icon_alpha);
      $display("icon overlay done");
      summarize;
   end
endmodule // video_overlay_window_control_bench
